// ### hw/tcp_array.sv
// tcp_array.sv: array of counter, capture and pwm channels
// assumes: one clock, synchronous inputs, software bits as plain ports
//
// Behaviour
// - There are thirty-two channels, each with its own period value.
// - The first eight channels are 32 bits wide, the rest 16 bits.
// - A capture event copies the channel count into its capture value.
// - At count equal to period the channel halts or reloads per option.
// - Count below the compare value gives the pwm duty output.
// - True and complement outputs are separated by programmable dead time.
// - The kill input forces every channel's true and complement outputs to the safe state at the next clock.
`timescale 1ns/100ps
`include "tcp_map.svh"
module tcp_array #(
   parameter int NCH   = `TCP_NUM_CH,
   parameter int NWIDE = `TCP_NUM_WIDE
) (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [NCH-1:0]           ch_enable,
   input  wire logic [NCH-1:0]           ch_oneshot,
   input  wire logic [NCH-1:0]           ch_tick,
   input  wire logic [NCH-1:0]           ch_capture,
   input  wire logic [NCH*32-1:0]        ch_period,
   input  wire logic [NCH*32-1:0]        ch_compare,
   input  wire logic [NCH*`TCP_DT_W-1:0] ch_deadtime,
   input  wire logic                     kill,
   output logic      [NCH*32-1:0]        ch_count,
   output logic      [NCH*32-1:0]        ch_capture_val,
   output logic      [NCH-1:0]           ch_running,
   output logic      [NCH-1:0]           pwm_true,
   output logic      [NCH-1:0]           pwm_compl
);
   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   // thirty-two channels
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      tcp_ch_if cif ();
      assign cif.enable   = ch_enable[i];
      assign cif.oneshot  = ch_oneshot[i];
      assign cif.tick     = ch_tick[i];
      assign cif.capture  = ch_capture[i];
      assign cif.period   = ch_period[i*32 +: 32];
      assign cif.cmp      = ch_compare[i*32 +: 32];
      assign cif.deadtime = ch_deadtime[i*`TCP_DT_W +: `TCP_DT_W];

      tcp_channel #(
         .W (i < NWIDE ? `TCP_WIDE_W : `TCP_NARROW_W)
      ) u_tcp_channel (
         .clk     (clk),
         .sys_rst (sys_rst),
         .c       (cif.ch)
      );

      // ------------------------------------------------------------
      // registered outputs
      // ------------------------------------------------------------
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            ch_count[i*32 +: 32]       <= '0;
            ch_capture_val[i*32 +: 32] <= '0;
            ch_running[i]              <= 1'b0;
         end else begin
            ch_count[i*32 +: 32]       <= cif.count;
            ch_capture_val[i*32 +: 32] <= cif.cap_val;
            ch_running[i]              <= cif.running;
         end
      end

      always_ff @(posedge clk) begin
         if (sys_rst || kill) begin
            pwm_true[i]  <= `TCP_SAFE_TRUE;
            pwm_compl[i] <= `TCP_SAFE_COMPL;
         end else begin
            pwm_true[i]  <= cif.out_true;
            pwm_compl[i] <= cif.out_compl;
         end
      end
   end
endmodule : tcp_array

// ### hw/tcp_channel.sv
// tcp_channel.sv: one counter channel with capture, compare, dead band
// assumes: synchronous inputs, kill handled by the top
`timescale 1ns/100ps
`include "tcp_map.svh"
module tcp_channel #(
   parameter int W = `TCP_NARROW_W
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   tcp_ch_if.ch      c
);
   logic [W-1:0]         cnt_q;
   logic [W-1:0]         cap_q;
   logic                 pwm_q;
   logic                 tru_q;
   logic                 cmp_q;
   logic [`TCP_DT_W-1:0] dt_q;
   tcp_pkg::tcp_state_t  st_q;
   logic                 at_per;

   assign at_per = (cnt_q == c.period[W-1:0]);

   // ------------------------------------------------------------
   // counting
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q  <= tcp_pkg::TCP_IDLE;
         cnt_q <= W'(`TCP_CNT_RST);
      end else begin
         case (st_q)
            tcp_pkg::TCP_IDLE: begin
               if (c.enable) begin
                  st_q <= tcp_pkg::TCP_RUN;
               end
            end
            tcp_pkg::TCP_RUN: begin
               if (!c.enable) begin
                  st_q <= tcp_pkg::TCP_IDLE;
               end else if (c.tick && at_per) begin
                  cnt_q <= W'(`TCP_CNT_RST);
                  if (c.oneshot) begin
                     st_q <= tcp_pkg::TCP_HALT;
                  end
               end else if (c.tick) begin
                  cnt_q <= cnt_q + W'(1);
               end
            end
            tcp_pkg::TCP_HALT: begin
               if (!c.enable) begin
                  st_q <= tcp_pkg::TCP_IDLE;
               end
            end
            default: st_q <= tcp_pkg::TCP_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // capture and compare
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cap_q <= '0;
      end else if (c.capture) begin
         cap_q <= cnt_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwm_q <= 1'b0;
      end else begin
         pwm_q <= (st_q == tcp_pkg::TCP_RUN) && (cnt_q < c.cmp[W-1:0]);
      end
   end

   // ------------------------------------------------------------
   // dead band: each output rises only after pwm is stable dt cycles
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmp_q <= 1'b0;
         dt_q  <= '0;
         tru_q <= 1'b0;
      end else begin
         cmp_q <= pwm_q;
         if (pwm_q != cmp_q) begin
            dt_q  <= '0;
            tru_q <= 1'b0;
         end else if (dt_q < c.deadtime) begin
            dt_q <= dt_q + `TCP_DT_W'(1);
         end else begin
            tru_q <= 1'b1;
         end
      end
   end

   assign c.count     = tcp_pkg::tcp_word_t'(cnt_q);
   assign c.cap_val   = tcp_pkg::tcp_word_t'(cap_q);
   assign c.pwm       = pwm_q;
   assign c.out_true  = tru_q & cmp_q;
   assign c.out_compl = tru_q & ~cmp_q;
   assign c.running   = (st_q == tcp_pkg::TCP_RUN);
endmodule : tcp_channel

// ### include/tcp_ch_if.sv
// tcp_ch_if.sv: signals between the array top and one channel
// assumes: one system clock
`timescale 1ns/100ps
`include "tcp_map.svh"
interface tcp_ch_if;
   logic                 enable;
   logic                 oneshot;
   logic                 tick;
   logic                 capture;
   tcp_pkg::tcp_word_t   period;
   tcp_pkg::tcp_word_t   cmp;
   logic [`TCP_DT_W-1:0] deadtime;
   tcp_pkg::tcp_word_t   count;
   tcp_pkg::tcp_word_t   cap_val;
   logic                 pwm;
   logic                 out_true;
   logic                 out_compl;
   logic                 running;
   modport top (output enable, oneshot, tick, capture, period, cmp,
      deadtime, input count, cap_val, pwm, out_true, out_compl, running);
   modport ch (input enable, oneshot, tick, capture, period, cmp,
      deadtime, output count, cap_val, pwm, out_true, out_compl,
      running);
endinterface : tcp_ch_if

// ### include/tcp_map.svh
// tcp_map.svh: fixed numbers of the counter/capture/pwm array
// assumes: included by its bare name from package and design files
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
`define TCP_NUM_CH      32
`define TCP_NUM_WIDE    8
`define TCP_WIDE_W      32
`define TCP_NARROW_W    16
`define TCP_DT_W        8
`define TCP_CNT_RST     32'h0000_0000
`define TCP_SAFE_TRUE   1'b0
`define TCP_SAFE_COMPL  1'b0
`endif

// ### include/tcp_pkg.sv
// tcp_pkg.sv: types shared by the array top and its channel
// assumes: tcp_map.svh on the include path
`include "tcp_map.svh"
package tcp_pkg;
   typedef enum logic [1:0] {
      TCP_IDLE,
      TCP_RUN,
      TCP_HALT
   } tcp_state_t;
   typedef logic [`TCP_WIDE_W-1:0] tcp_word_t;
endpackage : tcp_pkg

// ### tb/tb_tcp_array.sv
// tb_tcp_array.sv: self-checking bench for the channel array
// assumes: package, design, model and monitor compiled first
`timescale 1ns/100ps
`include "tcp_map.svh"
module tb_tcp_array;
   logic          clk;
   logic          sys_rst;
   logic          kill;
   logic [31:0]   en, os, tk, cap, run, pt, pc;
   logic [1023:0] per, cmp, cnt, capv;
   logic [255:0]  dt;
   int            bad_count, n_tests, hi0, lo0, hi1, lo1, sh;
   tcp_array u_tcp_array (.clk(clk), .sys_rst(sys_rst), .ch_enable(en),
      .ch_oneshot(os), .ch_tick(tk), .ch_capture(cap), .ch_period(per),
      .ch_compare(cmp), .ch_deadtime(dt), .kill(kill), .ch_count(cnt),
      .ch_capture_val(capv), .ch_running(run), .pwm_true(pt),
      .pwm_compl(pc));
   tcp_drv_model u_tcp_drv_model (.clk(clk), .gate_hi(pt[2]),
      .gate_lo(pc[2]), .n_hi(hi1), .n_lo(lo1), .n_shoot(sh));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic t_count;
      per[31:0] = 32'h0001_0003;
      per[63:32] = 32'h3;
      per[288 +: 32] = 32'h0001_0003;
      os[1] = 1'b1;
      en = 32'h0000_0203;
      step(1);
      tk = 32'h0000_0203;
      step(6);
      tk = '0;
      step(3);
      check(cnt[31:0], 32'h6);
      check(cnt[63:32], 32'h0);
      check(cnt[288 +: 32], 32'h2);
      check(run & 32'h203, 32'h201);
   endtask : t_count
   task automatic t_capture;
      cap[0] = 1'b1;
      step(1);
      cap[0] = 1'b0;
      step(3);
      check(capv[31:0], 32'h6);
   endtask : t_capture
   task automatic t_pwm;
      per[95:64] = 32'h9;
      cmp[95:64] = 32'h5;
      dt[23:16] = 8'h2;
      en[2] = 1'b1;
      tk[2] = 1'b1;
      step(25);
      hi0 = hi1;
      lo0 = lo1;
      step(40);
      check(32'(hi1 - hi0), 32'h8);
      check(32'(lo1 - lo0), 32'h8);
      check(32'(sh), 32'h0);
   endtask : t_pwm
   task automatic t_kill;
      kill = 1'b1;
      step(1);
      check(pt | pc, 32'h0);
      kill = 1'b0;
   endtask : t_kill
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      {sys_rst, kill, en, os, tk, cap} = {2'h2, 128'h0};
      {per, cmp, dt} = '0;
      step(11);
      sys_rst = 1'b0;
      step(1);
      check(cnt[31:0] | run | pt | pc, 32'h0);
      t_count();
      t_capture();
      t_pwm();
      t_kill();
      print_verdict();
   end
endmodule : tb_tcp_array
bind tcp_array tcp_array_monitor #(.NCH(NCH), .NWIDE(NWIDE))
   u_tcp_array_monitor (.clk(clk), .sys_rst(sys_rst), .kill(kill),
   .ch_enable(ch_enable), .ch_oneshot(ch_oneshot), .ch_tick(ch_tick),
   .ch_capture(ch_capture), .ch_count(ch_count), .pwm_true(pwm_true),
   .ch_capture_val(ch_capture_val), .ch_running(ch_running),
   .pwm_compl(pwm_compl));

// ### tb/tcp_array_monitor.sv
// tcp_array_monitor.sv: assertions on the array ports
// assumes: bound to tcp_array, one clock
`timescale 1ns/100ps
module tcp_array_monitor #(
   parameter int NCH   = 32,
   parameter int NWIDE = 8
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [NCH-1:0]    ch_enable,
   input wire logic [NCH-1:0]    ch_oneshot,
   input wire logic [NCH-1:0]    ch_tick,
   input wire logic [NCH-1:0]    ch_capture,
   input wire logic              kill,
   input wire logic [NCH*32-1:0] ch_count,
   input wire logic [NCH*32-1:0] ch_capture_val,
   input wire logic [NCH-1:0]    ch_running,
   input wire logic [NCH-1:0]    pwm_true,
   input wire logic [NCH-1:0]    pwm_compl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_en2;
      (!sys_rst && ch_enable[0] && !ch_oneshot[0]) [*2];
   endsequence
   sequence s_cap;
      ch_capture[0] ##2 1'b1;
   endsequence
   AST_RUN: assert property (s_en2 |=> ch_running[0])
      else $error("run flag late");
   AST_NARROW: assert property (ch_count[304 +: 16] == 16'h0 &&
      ch_capture_val[304 +: 16] == 16'h0)
      else $error("narrow upper bits set");
   AST_CAP: assert property (s_cap |->
      ch_capture_val[31:0] == $past(ch_count[31:0]))
      else $error("capture value wrong");
   AST_STEP: assert property (ch_count[31:0] == '0 ||
      ch_count[31:0] - $past(ch_count[31:0]) <= 32'h1)
      else $error("count jumped");
   AST_GAP: assert property ($rose(pwm_true[2]) |->
      $past(!pwm_compl[2]) && !pwm_compl[2])
      else $error("no dead band");
   AST_SHOOT: assert property ((pwm_true & pwm_compl) == '0)
      else $error("both outputs high");
   AST_KILL: assert property (kill |=> pwm_true == '0 &&
      pwm_compl == '0) else $error("kill ignored");
   AST_HOLD: assert property (!ch_tick[0] |-> ##2
      $stable(ch_count[31:0])) else $error("count moved without tick");
   AST_RST: assert property (disable iff (1'b0) sys_rst |=>
      ch_count == '0 && ch_running == '0 && pwm_true == '0)
      else $error("outputs not cleared");
endmodule : tcp_array_monitor

// ### tb/tcp_drv_model.sv
// tcp_drv_model.sv: switch driver pair fed by one channel's outputs
// assumes: gate inputs active high, settled at rising clk
`timescale 1ns/100ps
module tcp_drv_model (
   input  wire logic clk,
   input  wire logic gate_hi,
   input  wire logic gate_lo,
   output int        n_hi,
   output int        n_lo,
   output int        n_shoot
);
   initial begin
      n_hi = 0;
      n_lo = 0;
      n_shoot = 0;
      forever begin
         @(posedge clk);
         n_hi += int'(gate_hi);
         n_lo += int'(gate_lo);
         n_shoot += int'(gate_hi && gate_lo);
      end
   end
endmodule : tcp_drv_model
